// ==== include/feistel_defines.svh ====
/*
  Timing counts, key-schedule constants and reset values for the 64-bit
  Feistel block cipher core.
  Assumes: included by bare name from the package and the design files.
*/
`ifndef FEISTEL_DEFINES_SVH
`define FEISTEL_DEFINES_SVH

// ----------------------------------------------------------------------------
// Block and key geometry
// ----------------------------------------------------------------------------
`define BLOCK_W       64
`define HALF_W        32
`define KEY_IN_W      64
`define KEY_EFF_W     56
`define SUBKEY_W      48

// ----------------------------------------------------------------------------
// Round sequencing
// ----------------------------------------------------------------------------
`define ROUND_FIRST   4'h0
`define ROUND_LAST    4'hf
// Bit i set: round i rotates the key halves by two places, else by one
`define KEY_SHIFT2    16'h7efc

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define HALF_RST      32'h0000_0000
`define CD_RST        56'h00_0000_0000_0000
`define BLOCK_RST     64'h0000_0000_0000_0000

`endif

// ==== include/feistel_pkg.sv ====
/*
  Types shared by the cipher core and its output buffer.
  Assumes: feistel_defines.svh is on the include path.
*/
`include "feistel_defines.svh"

package feistel_pkg;

  // --------------------------------------------------------------------------
  // Core sequencing
  // --------------------------------------------------------------------------
  typedef enum logic {
    PH_IDLE,
    PH_RUN
  } phase_e;

  // All state of the cipher core
  typedef struct packed {
    phase_e                   phase;   // Idle or rounds in progress
    logic [3:0]               round;   // Round now being computed
    logic                     enc;     // Captured direction, 1 = encrypt
    logic [`HALF_W-1:0]       left;    // Left half register
    logic [`HALF_W-1:0]       right;   // Right half register
    logic [`KEY_EFF_W-1:0]    cd;      // Key halves C and D
    logic                     go_prev; // Launch level one cycle ago
  } core_s;

  // --------------------------------------------------------------------------
  // Output buffer
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic                     valid;
    logic [`BLOCK_W-1:0]      data;
  } word_s;

  // All state of the two-entry buffer
  typedef struct packed {
    word_s                    head;    // Entry shown at the output
    word_s                    tail;    // Overflow entry behind it
  } buf_s;

endpackage : feistel_pkg

// ==== src/result_buffer.sv ====
/*
  Two-entry result buffer with valid/ready on both sides.
  Assumes: one clock, synchronous active-high reset, both sides on clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
`include "feistel_defines.svh"

module result_buffer (
  input  wire logic                 clk_i,       // System clock
  input  wire logic                 sys_rst_i,   // Synchronous reset
  input  wire logic                 in_valid_i,  // Word offered
  input  wire logic [`BLOCK_W-1:0]  in_data_i,   // Offered word
  output logic                      in_ready_o,  // Room for a word
  output logic                      out_valid_o, // Head word valid
  output logic [`BLOCK_W-1:0]       out_data_o,  // Head word
  input  wire logic                 out_ready_i  // Receiver takes head
);

  feistel_pkg::buf_s state_q;  // Registered state
  feistel_pkg::buf_s state_d;  // Next state

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  // Pop first, then push into the first free slot; the tail stays full
  // while the receiver stalls, which is what throttles the core.
  always_comb begin
    state_d = state_q;
    if (state_q.head.valid && out_ready_i) begin
      state_d.head       = state_q.tail;
      state_d.tail.valid = 1'b0;
    end
    if (in_valid_i && !state_q.tail.valid) begin
      if (!state_d.head.valid) begin
        state_d.head.valid = 1'b1;
        state_d.head.data  = in_data_i;
      end else begin
        state_d.tail.valid = 1'b1;
        state_d.tail.data  = in_data_i;
      end
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs straight from the entries
  assign in_ready_o  = !state_q.tail.valid;
  assign out_valid_o = state_q.head.valid;
  assign out_data_o  = state_q.head.data;

endmodule : result_buffer

`default_nettype wire

// ==== src/feistel_block_cipher_64.sv ====
/*
  Iterative 64-bit Feistel block cipher core, one round per clock, with a
  two-entry buffer on the result path.
  Assumes: launch, data, key and direction come from logic on clk_i; the
  receiver of results is on clk_i as well.
*/
`timescale 1ns/1ps
`default_nettype none
`include "feistel_defines.svh"

module feistel_block_cipher_64 (
  input  wire logic                 clk_i,        // System clock
  input  wire logic                 sys_rst_i,    // Synchronous reset
  input  wire logic                 go_i,         // Launch, rising edge
  input  wire logic                 enc_i,        // 1 encrypt, 0 decrypt
  input  wire logic [`BLOCK_W-1:0]  din_i,        // Input block
  input  wire logic [`KEY_IN_W-1:0] key_i,        // Key field with parity
  input  wire logic                 out_ready_i,  // Receiver takes result
  output logic [`BLOCK_W-1:0]       dout_o,       // Result block
  output logic                      ready_o       // Result valid
);

  // --------------------------------------------------------------------------
  // Permutation tables, entries numbered from 1 at the most significant bit
  // --------------------------------------------------------------------------
  localparam int IP_T [64] = '{
    58, 50, 42, 34, 26, 18, 10, 2, 60, 52, 44, 36, 28, 20, 12, 4,
    62, 54, 46, 38, 30, 22, 14, 6, 64, 56, 48, 40, 32, 24, 16, 8,
    57, 49, 41, 33, 25, 17, 9, 1, 59, 51, 43, 35, 27, 19, 11, 3,
    61, 53, 45, 37, 29, 21, 13, 5, 63, 55, 47, 39, 31, 23, 15, 7};
  localparam int FP_T [64] = '{
    40, 8, 48, 16, 56, 24, 64, 32, 39, 7, 47, 15, 55, 23, 63, 31,
    38, 6, 46, 14, 54, 22, 62, 30, 37, 5, 45, 13, 53, 21, 61, 29,
    36, 4, 44, 12, 52, 20, 60, 28, 35, 3, 43, 11, 51, 19, 59, 27,
    34, 2, 42, 10, 50, 18, 58, 26, 33, 1, 41, 9, 49, 17, 57, 25};
  localparam int E_T [48] = '{
    32, 1, 2, 3, 4, 5, 4, 5, 6, 7, 8, 9, 8, 9, 10, 11,
    12, 13, 12, 13, 14, 15, 16, 17, 16, 17, 18, 19, 20, 21, 20, 21,
    22, 23, 24, 25, 24, 25, 26, 27, 28, 29, 28, 29, 30, 31, 32, 1};
  localparam int P_T [32] = '{
    16, 7, 20, 21, 29, 12, 28, 17, 1, 15, 23, 26, 5, 18, 31, 10,
    2, 8, 24, 14, 32, 27, 3, 9, 19, 13, 30, 6, 22, 11, 4, 25};
  // Skips positions 8, 16, ... 64: the parity bits never reach the rounds
  localparam int PC1_T [56] = '{
    57, 49, 41, 33, 25, 17, 9, 1, 58, 50, 42, 34, 26, 18,
    10, 2, 59, 51, 43, 35, 27, 19, 11, 3, 60, 52, 44, 36,
    63, 55, 47, 39, 31, 23, 15, 7, 62, 54, 46, 38, 30, 22,
    14, 6, 61, 53, 45, 37, 29, 21, 13, 5, 28, 20, 12, 4};
  localparam int PC2_T [48] = '{
    14, 17, 11, 24, 1, 5, 3, 28, 15, 6, 21, 10, 23, 19, 12, 4,
    26, 8, 16, 7, 27, 20, 13, 2, 41, 52, 31, 37, 47, 55, 30, 40,
    51, 45, 33, 48, 44, 49, 39, 56, 34, 53, 46, 42, 50, 36, 29, 32};

  // --------------------------------------------------------------------------
  // Substitution boxes: 64 nibbles each, row-major, first entry on top
  // --------------------------------------------------------------------------
  localparam logic [255:0] SBOX_T [8] = '{
    256'he4d12fb83a6c5907_0f74e2d1a6cb9538_41e8d62bfc973a50_fc8249175b3ea06d,
    256'hf18e6b34972dc05a_3d47f28ec01a69b5_0e7ba4d158c6932f_d8a13f42b67c05e9,
    256'ha09e63f51dc7b428_d709346a285ecbf1_d6498f30b12c5ae7_1ad069874fe3b52c,
    256'h7de3069a1285bc4f_d8b56f03472c1ae9_a690cb7df13e5284_3f06a1d8945bc72e,
    256'h2c417ab6853fd0e9_eb2c47d150fa3986_421bad78f9c5630e_b8c71e2d6f09a453,
    256'hc1af92680d34e75b_af427c9561de0b38_9ef528c3704a1db6_432c95fabe17608d,
    256'h4b2ef08d3c975a61_d0b7491ae35c2f86_14bdc37eaf680592_6bd814a7950fe23c,
    256'hd2846fb1a93e50c7_1fd8a374c56b0e92_7b419ce206adf358_21e74a8dfc90356b};

  // --------------------------------------------------------------------------
  // Permutation and lookup functions
  // --------------------------------------------------------------------------
  // Initial permutation of the input block
  function automatic logic [63:0] ip_f(input logic [63:0] x);
    logic [63:0] y;
    y = '0;
    for (int i = 0; i < 64; i++) begin
      y[63-i] = x[64-IP_T[i]];
    end
    return y;
  endfunction : ip_f

  // Inverse of the initial permutation
  function automatic logic [63:0] fp_f(input logic [63:0] x);
    logic [63:0] y;
    y = '0;
    for (int i = 0; i < 64; i++) begin
      y[63-i] = x[64-FP_T[i]];
    end
    return y;
  endfunction : fp_f

  // Key selection: 64 key bits down to the 56 that matter
  function automatic logic [55:0] pc1_f(input logic [63:0] x);
    logic [55:0] y;
    y = '0;
    for (int i = 0; i < 56; i++) begin
      y[55-i] = x[64-PC1_T[i]];
    end
    return y;
  endfunction : pc1_f

  // Subkey selection from the key halves
  function automatic logic [47:0] pc2_f(input logic [55:0] x);
    logic [47:0] y;
    y = '0;
    for (int i = 0; i < 48; i++) begin
      y[47-i] = x[56-PC2_T[i]];
    end
    return y;
  endfunction : pc2_f

  // Rotate both 28-bit key halves left or right by one or two
  function automatic logic [55:0] rot_f(input logic [55:0] cd,
                                       input logic        left,
                                       input logic        two);
    logic [27:0] c;
    logic [27:0] d;
    c = cd[55:28];
    d = cd[27:0];
    if (left && two) begin
      c = {c[25:0], c[27:26]};
      d = {d[25:0], d[27:26]};
    end else if (left) begin
      c = {c[26:0], c[27]};
      d = {d[26:0], d[27]};
    end else if (two) begin
      c = {c[1:0], c[27:2]};
      d = {d[1:0], d[27:2]};
    end else begin
      c = {c[0], c[27:1]};
      d = {d[0], d[27:1]};
    end
    return {c, d};
  endfunction : rot_f

  // Round function: expand, mix key, substitute, permute
  function automatic logic [31:0] feistel_f(input logic [31:0] r,
                                           input logic [47:0] k);
    logic [47:0] e;
    logic [31:0] s;
    logic [31:0] p;
    logic [5:0]  b;
    int          idx;
    e   = '0;
    s   = '0;
    p   = '0;
    b   = '0;
    idx = 0;
    for (int i = 0; i < 48; i++) begin
      e[47-i] = r[32-E_T[i]];
    end
    e = e ^ k;
    for (int g = 0; g < 8; g++) begin
      b   = e[47-6*g -: 6];
      idx = int'({b[5], b[0], b[4:1]});
      s[31-4*g -: 4] = SBOX_T[g][255-4*idx -: 4];
    end
    for (int i = 0; i < 32; i++) begin
      p[31-i] = s[32-P_T[i]];
    end
    return p;
  endfunction : feistel_f

  // --------------------------------------------------------------------------
  // State and round datapath
  // --------------------------------------------------------------------------
  feistel_pkg::core_s   state_q;     // Registered core state
  feistel_pkg::core_s   state_d;     // Next core state
  logic                 launch_edge; // Rising edge seen on go_i
  logic                 last_round;  // Final round in progress
  logic                 push_ready;  // Buffer has room
  logic                 accept;      // Launch taken this cycle
  logic                 push_valid;  // Result offered to buffer
  logic                 shift_two;   // This round rotates by two
  logic [55:0]          cd_use;      // Key halves feeding the subkey
  logic [55:0]          cd_next;     // Key halves for the next round
  logic [47:0]          subkey;      // Subkey of this round
  logic [31:0]          right_new;   // Right half after this round
  logic [63:0]          result;      // Finished block
  logic [63:0]          ip_block;    // Permuted input block
  logic                 pop;         // Head of buffer consumed

  // Edge found against last cycle's level; go_i is same-domain logic
  assign launch_edge = go_i && !state_q.go_prev;
  assign last_round  = (state_q.phase == feistel_pkg::PH_RUN) &&
                       (state_q.round == `ROUND_LAST);
  // A launch may land on the final round, so blocks follow with no gap
  assign accept      = launch_edge &&
                       ((state_q.phase == feistel_pkg::PH_IDLE) ||
                        (last_round && push_ready));
  assign push_valid  = last_round;

  // --------------------------------------------------------------------------
  // Key schedule
  // --------------------------------------------------------------------------
  // Rotation amounts per round, bit i for round i; indexed, not shifted,
  // so only the one wanted bit reaches the single-bit select
  localparam logic [15:0] SHIFT_MAP = `KEY_SHIFT2;

  // Encrypt rotates left before use; decrypt uses then rotates right, with
  // the rotation amounts walked in reverse order.
  always_comb begin
    shift_two = 1'b0;
    cd_use    = state_q.cd;
    cd_next   = state_q.cd;
    if (state_q.enc) begin
      shift_two = SHIFT_MAP[state_q.round];
      cd_use    = rot_f(state_q.cd, 1'b1, shift_two);
      cd_next   = cd_use;
    end else begin
      shift_two = SHIFT_MAP[`ROUND_LAST - state_q.round];
      cd_next   = rot_f(state_q.cd, 1'b0, shift_two);
    end
  end

  assign subkey    = pc2_f(cd_use);
  assign right_new = state_q.left ^ feistel_f(state_q.right, subkey);
  // Halves are not swapped after the last round
  assign result    = fp_f({right_new, state_q.right});
  assign ip_block  = ip_f(din_i);

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  // The final round holds while the buffer is full, so a stalled receiver
  // never loses a result; a launch during that stall is ignored.
  always_comb begin
    state_d         = state_q;
    state_d.go_prev = go_i;
    case (state_q.phase)
      feistel_pkg::PH_IDLE: begin
        // Waiting for a launch
      end
      feistel_pkg::PH_RUN: begin
        if (!last_round) begin
          // One round per clock
          state_d.left  = state_q.right;
          state_d.right = right_new;
          state_d.cd    = cd_next;
          state_d.round = state_q.round + 4'h1;
        end else if (push_ready) begin
          // Result leaves for the buffer
          state_d.phase = feistel_pkg::PH_IDLE;
        end
      end
      default: begin
        state_d.phase = feistel_pkg::PH_IDLE;
      end
    endcase
    if (accept) begin
      // Capture block, key and direction on the launch edge
      state_d.phase = feistel_pkg::PH_RUN;
      state_d.round = `ROUND_FIRST;
      state_d.enc   = enc_i;
      state_d.left  = ip_block[63:32];
      state_d.right = ip_block[31:0];
      state_d.cd    = pc1_f(key_i);
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q.phase   <= feistel_pkg::PH_IDLE;
      state_q.round   <= `ROUND_FIRST;
      state_q.enc     <= 1'b1;
      state_q.left    <= `HALF_RST;
      state_q.right   <= `HALF_RST;
      state_q.cd      <= `CD_RST;
      state_q.go_prev <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  // --------------------------------------------------------------------------
  // Result buffer
  // --------------------------------------------------------------------------
  // A taken launch also retires the shown result, so ready drops as the
  // new operation begins unless a second result is held or one is pushed
  // in the same cycle; the host reads before it relaunches.
  assign pop = out_ready_i || accept;

  result_buffer u_result_buffer (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (push_valid),
    .in_data_i   (result),
    .in_ready_o  (push_ready),
    .out_valid_o (ready_o),
    .out_data_o  (dout_o),
    .out_ready_i (pop)
  );

endmodule : feistel_block_cipher_64

`default_nettype wire

// ==== verification/feistel_block_cipher_64_properties.sv ====
/* Port checker for the cipher core: latency, buffer order and hold.
   Assumes: bound to feistel_block_cipher_64; one clock domain. */
`timescale 1ns/1ps
`default_nettype none
`include "feistel_defines.svh"

module feistel_block_cipher_64_properties (
  input  wire logic                 clk_i,
  input  wire logic                 sys_rst_i,
  input  wire logic                 go_i,
  input  wire logic                 enc_i,
  input  wire logic [`BLOCK_W-1:0]  din_i,
  input  wire logic [`KEY_IN_W-1:0] key_i,
  input  wire logic                 out_ready_i,
  input  wire logic [`BLOCK_W-1:0]  dout_o,
  input  wire logic                 ready_o
);
  // ------
  // Shadow of round count and buffer fill
  // ------
  logic [4:0] bcnt_q;  // 0 idle, 1..16 rounds in flight
  logic [1:0] occ_q;   // Words held in the buffer
  logic       gprev_q; // Launch level at last edge
  logic       acc;     // Launch taken at this edge
  logic       comp;    // Final round at this edge
  logic       pop;     // Head leaves at this edge
  assign acc  = go_i && !gprev_q && (bcnt_q == 5'h00 || bcnt_q == 5'h10);
  assign comp = (bcnt_q == 5'h10);
  assign pop  = ready_o && (out_ready_i || acc);

  // Reset leaves the last level high, so a held launch does not fire
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      bcnt_q  <= 5'h00;
      occ_q   <= 2'h0;
      gprev_q <= 1'b1;
    end else begin
      bcnt_q  <= acc ? 5'h01 : ((bcnt_q != 5'h00 && !comp) ? bcnt_q + 5'h01 : 5'h00);
      occ_q   <= occ_q + {1'b0, comp} - {1'b0, pop};
      gprev_q <= go_i;
    end
  end

  // ------
  // Properties
  // ------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_fresh;
    acc && bcnt_q == 5'h00 && !ready_o;
  endsequence
  sequence s_rounds;
    !ready_o [*8] ##1 !ready_o [*8];
  endsequence

  property p_rst_clear;
    disable iff (1'b0) sys_rst_i |=> !ready_o && dout_o == `BLOCK_RST;
  endproperty
  property p_latency;
    s_fresh |=> s_rounds ##1 ready_o;
  endproperty
  property p_occ;
    ready_o == (occ_q != 2'h0);
  endproperty
  property p_b2b;
    acc && comp && !ready_o |=> ready_o;
  endproperty
  property p_hold;
    ready_o && !pop |=> ready_o && $stable(dout_o);
  endproperty
  property p_pop_last;
    pop && occ_q == 2'h1 && !comp |=> !ready_o;
  endproperty
  property p_launch_pop;
    acc && ready_o && occ_q == 2'h1 && !comp |=> !ready_o;
  endproperty
  property p_pop_next;
    pop && occ_q == 2'h2 |=> ready_o;
  endproperty

  a_rst_clear: assert property (p_rst_clear) else $error("output not cleared by reset");
  a_latency: assert property (p_latency) else $error("ready not sixteen cycles after launch");
  a_occ: assert property (p_occ) else $error("ready disagrees with results held");
  a_b2b: assert property (p_b2b) else $error("back to back launch lost a result");
  a_hold: assert property (p_hold) else $error("result moved before it was taken");
  a_pop_last: assert property (p_pop_last) else $error("ready stayed after last word taken");
  a_launch_pop: assert property (p_launch_pop) else $error("ready stayed after new launch");
  a_pop_next: assert property (p_pop_next) else $error("second word not shown");
endmodule : feistel_block_cipher_64_properties
`default_nettype wire

// ==== verification/feistel_host_model.sv ====
/* Host logic model: presents blocks, keys and direction, takes results.
   Assumes: bench calls tasks just after a rising clock edge. */
`timescale 1ns/1ps
`default_nettype none

module feistel_host_model (
  input  wire logic        clk_i,
  input  wire logic        ready_i,
  input  wire logic [63:0] dout_i,
  output logic             go_o,
  output logic             enc_o,
  output logic [63:0]      din_o,
  output logic [63:0]      key_o,
  output logic             out_ready_o
);
  // Quiet lines at time zero
  initial begin
    go_o        = 1'b0;
    enc_o       = 1'b1;
    din_o       = 64'h0;
    key_o       = 64'h0;
    out_ready_o = 1'b0;
  end

  // One launch; go must have been low at the previous edge
  task automatic launch(input logic e, input logic [63:0] d, input logic [63:0] k);
    go_o  = 1'b1;
    enc_o = e;
    din_o = d;
    key_o = k;
    @(posedge clk_i);
    #1;
    go_o  = 1'b0;
    // Released lines show the inverse, never a stale copy
    enc_o = ~e;
    din_o = ~d;
    key_o = ~k;
  endtask : launch

  // Take one result only while ready is high, bounded wait
  task automatic take(output logic [63:0] v, output bit ok);
    int i;
    ok = 1'b0;
    v  = 64'h0;
    out_ready_o = 1'b1;
    for (i = 0; i < 40 && !ok; i++) begin
      @(posedge clk_i);
      if (ready_i === 1'b1) begin
        ok = 1'b1;
        v  = dout_i;
      end
    end
    #1;
    out_ready_o = 1'b0;
  endtask : take
endmodule : feistel_host_model
`default_nettype wire

// ==== verification/feistel_block_cipher_64_bench.sv ====
/* Self-checking bench for the cipher core with a host model.
   Assumes: checker and host model compiled before this file. */
`timescale 1ns/1ps
`default_nettype none

module feistel_block_cipher_64_bench;
  // ------
  // Clock, reset, wiring
  // ------
  logic        clk_i       = 1'b0;
  logic        sys_rst_i   = 1'b1;
  logic        go;
  logic        enc;
  logic        out_ready;
  logic        ready;
  logic [63:0] din;
  logic [63:0] key;
  logic [63:0] dout;
  logic [63:0] v;
  int          n_fail      = 0;
  int          checks_done = 0;
  // Known answer set: direction, key, input, expected
  logic        ve [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  logic [63:0] vk [6] = '{64'h1334_5779_9bbc_dff1, 64'h1334_5779_9bbc_dff1, 64'h0e32_9232_ea6d_0d73,
                          64'h0e32_9232_ea6d_0d73, 64'h1235_5678_9abd_def0, 64'h0f33_9333_eb6c_0c72};
  logic [63:0] vd [6] = '{64'h0123_4567_89ab_cdef, 64'h85e8_1354_0f0a_b405, 64'h8787_8787_8787_8787,
                          64'h0, 64'h0123_4567_89ab_cdef, 64'h0};
  logic [63:0] vx [6] = '{64'h85e8_1354_0f0a_b405, 64'h0123_4567_89ab_cdef, 64'h0,
                          64'h8787_8787_8787_8787, 64'h85e8_1354_0f0a_b405, 64'h8787_8787_8787_8787};

  always #2.5 clk_i = ~clk_i;

  feistel_block_cipher_64 dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .go_i(go), .enc_i(enc), .din_i(din),
                               .key_i(key), .out_ready_i(out_ready), .dout_o(dout), .ready_o(ready));
  feistel_host_model host (.clk_i(clk_i), .ready_i(ready), .dout_i(dout), .go_o(go), .enc_o(enc),
                           .din_o(din), .key_o(key), .out_ready_o(out_ready));

  // ------
  // Shared tasks
  // ------
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // A missing result ends the run
  task automatic get(output logic [63:0] r);
    bit ok;
    host.take(r, ok);
    if (!ok) begin
      n_fail++;
      results();
    end
  endtask : get

  task automatic results();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  // ------
  // Scenarios
  // ------
  // Both directions, two keys, parity bits flipped in the last two
  task automatic t_vectors();
    for (int i = 0; i < 6; i++) begin
      host.launch(ve[i], vd[i], vk[i]);
      get(v);
      chk(v, vx[i]);
      step(1);
    end
    $display("vectors done");
  endtask : t_vectors

  // Count edges from launch to ready, looking just after each edge
  task automatic t_latency();
    int n;
    host.launch(1'b1, vd[0], vk[0]);
    for (n = 1; n < 40; n++) begin
      step(1);
      if (ready === 1'b1) break;
    end
    chk(64'(n), 64'h10);
    get(v);
    chk(v, vx[0]);
    step(1);
    $display("latency done");
  endtask : t_latency

  // Launch on the final-round edge (edge 16) with new key and direction; receiver stalls
  task automatic t_b2b();
    host.launch(1'b1, vd[0], vk[0]);
    step(15);
    host.launch(1'b0, vx[2], vk[2]);
    step(20);
    chk({63'h0, ready}, 64'h1);
    get(v);
    chk(v, vx[0]);
    step(1);
    get(v);
    chk(v, vd[2]);
    step(1);
    $display("back to back done");
  endtask : t_b2b

  // A new launch drops ready
  task automatic t_launch_pop();
    host.launch(1'b1, vd[2], vk[2]);
    step(20);
    chk({63'h0, ready}, 64'h1);
    host.launch(1'b1, vd[0], vk[0]);
    chk({63'h0, ready}, 64'h0);
    get(v);
    chk(v, vx[0]);
    step(1);
    $display("launch pop done");
  endtask : t_launch_pop

  // Launch during rounds is ignored
  task automatic t_refuse();
    host.launch(1'b1, vd[0], vk[0]);
    step(4);
    host.launch(1'b0, vx[2], vk[2]);
    get(v);
    chk(v, vx[0]);
    step(20);
    chk({63'h0, ready}, 64'h0);
    $display("refuse done");
  endtask : t_refuse

  // Reset mid-run discards the operation
  task automatic t_reset();
    host.launch(1'b1, vd[0], vk[0]);
    step(5);
    sys_rst_i = 1'b1;
    step(2);
    sys_rst_i = 1'b0;
    step(20);
    chk({63'h0, ready}, 64'h0);
    $display("reset done");
  endtask : t_reset

  initial begin
    repeat (16) @(posedge clk_i);
    #1;
    sys_rst_i = 1'b0;
    step(2);
    t_vectors();
    t_latency();
    t_b2b();
    t_launch_pop();
    t_refuse();
    t_reset();
    results();
  end
endmodule : feistel_block_cipher_64_bench

bind feistel_block_cipher_64 feistel_block_cipher_64_properties props (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .go_i(go_i), .enc_i(enc_i), .din_i(din_i), .key_i(key_i), .out_ready_i(out_ready_i), .dout_o(dout_o),
  .ready_o(ready_o));
`default_nettype wire
